// ### result_readback_map.svh
`ifndef RESULT_READBACK_MAP_SVH
`define RESULT_READBACK_MAP_SVH
// per-port register select codes (byte address = select * 4)
`define RB_SEL_CONTROL  4'h3
`define RB_SEL_STATE    4'h5
`define RB_SEL_DET_LO   4'h6
`define RB_SEL_DET_HI   4'h7
`define RB_SEL_VOLT_LO  4'h8
`define RB_SEL_VOLT_HI  4'h9
// global page select codes
`define RB_SEL_IRQ_STAT 4'h0
`define RB_SEL_IRQ_EN   4'h1
`define RB_SEL_IRQ_CLR  4'h2
// address fields
`define RB_GLOBAL_BIT   8
`define RB_PORT_MSB     7
`define RB_PORT_LSB     6
`define RB_SEL_MSB      5
`define RB_SEL_LSB      2
// field positions
`define RB_CTRL_START   3
`define RB_CTRL_ABORT   2
`define RB_STATE_ACTIVE 3
`define RB_FLAG_BIT     7
`define RB_RESULT_W     15
// reset values
`define RB_RESULT_RST   15'h0000
`define RB_FLAG_RST     1'b0
`define RB_SYNC_RST     2'h0
`define RB_WORD_RST     32'h0000_0000
`endif

// ### rb_pkg.sv
`default_nettype none
package rb_pkg;
    // port operating-state codes
    typedef enum logic [2:0] {
        ST_DISABLED    = 3'h0,
        ST_SEARCHING   = 3'h1,
        ST_POWERED     = 3'h2,
        ST_FAULT       = 3'h3,
        ST_TEST        = 3'h4,
        ST_OTHER_FAULT = 3'h5,
        ST_UNDEF_6     = 3'h6,
        ST_UNDEF_7     = 3'h7
    } port_state_t;
    // bus answer states, one-hot
    typedef enum logic [1:0] {
        APB_IDLE   = 2'h1,
        APB_ANSWER = 2'h2
    } apb_state_t;
endpackage : rb_pkg
`default_nettype wire

// ### port_result_slot.sv
`timescale 1ns/100ps
`default_nettype none
`include "result_readback_map.svh"
module port_result_slot (
    input  wire logic                    clk,
    input  wire logic                    rst_sync_n,
    input  wire logic                    clk_en,
    input  wire logic                    detect_begin,
    input  wire logic                    detect_done,
    input  wire logic                    voltage_begin,
    input  wire logic                    voltage_done,
    input  wire logic [`RB_RESULT_W-1:0] conv_data,
    output logic      [`RB_RESULT_W:0]   det_word_q,
    output logic      [`RB_RESULT_W:0]   volt_word_q
);
    // detection result: flag on top, data below, written at one edge
    // whole word at once on done, flag bit alone on begin
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            det_word_q <= {`RB_FLAG_RST, `RB_RESULT_RST};
        end else if (clk_en) begin
            if (detect_done) begin
                det_word_q <= {1'b1, conv_data};
            end else if (detect_begin) begin
                det_word_q[`RB_RESULT_W] <= 1'b0;
            end
        end
    end

    // voltage result: same scheme
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            volt_word_q <= {`RB_FLAG_RST, `RB_RESULT_RST};
        end else if (clk_en) begin
            if (voltage_done) begin
                volt_word_q <= {1'b1, conv_data};
            end else if (voltage_begin) begin
                volt_word_q[`RB_RESULT_W] <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    a_det_flag_low: assert property (
        clk_en && detect_begin && !detect_done |=> !det_word_q[`RB_RESULT_W])
        else $error("detect flag not cleared at start");
    a_det_done_data: assert property (
        clk_en && detect_done |=> det_word_q == {1'b1, $past(conv_data)})
        else $error("detect result or flag wrong");
    a_volt_flag_low: assert property (
        clk_en && voltage_begin && !voltage_done |=> !volt_word_q[`RB_RESULT_W])
        else $error("voltage flag not cleared at start");
    a_volt_done_data: assert property (
        clk_en && voltage_done |=> volt_word_q == {1'b1, $past(conv_data)})
        else $error("voltage result or flag wrong");
    a_flag_rise_cause: assert property (
        $rose(volt_word_q[`RB_RESULT_W]) |-> $past(voltage_done) && $past(clk_en))
        else $error("voltage flag rose without result update");
endmodule : port_result_slot
`default_nettype wire

// ### port_adc_result_readback.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "result_readback_map.svh"
module port_adc_result_readback #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst_n,
    input  wire logic                            clk_en,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [8:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire rb_pkg::port_state_t [NUM_PORTS-1:0] port_state_in,
    input  wire logic [NUM_PORTS-1:0]            detect_begin,
    input  wire logic [NUM_PORTS-1:0]            detect_done,
    input  wire logic [NUM_PORTS-1:0]            voltage_begin,
    input  wire logic [NUM_PORTS-1:0]            voltage_done,
    input  wire logic [NUM_PORTS*15-1:0]         conv_data,
    output logic      [NUM_PORTS-1:0]            adc_start,
    output logic      [NUM_PORTS-1:0]            adc_abort,
    output logic                                 irq
);
    import rb_pkg::*;

    localparam int IRQ_W = 2 * NUM_PORTS;   // detect and voltage events

    logic                  rst_meta_q;      // reset release, stage one
    logic                  rst_sync_q;      // reset release, stage two
    apb_state_t            apb_state_q;     // bus answer state
    logic [31:0]           prdata_q;        // registered read data
    logic                  pready_q;        // registered ready
    logic                  pslverr_q;       // registered error
    logic [31:0]           rd_data_d;       // read mux result
    logic                  rd_err_d;        // unmapped address
    logic                  go;              // access phase taken
    logic                  commit;          // transfer ends this edge
    logic                  is_global;       // global page hit
    logic [1:0]            port_idx;        // port field
    logic [3:0]            sel;             // register select field
    logic                  port_ok;         // port exists
    logic [NUM_PORTS-1:0]  start_q;         // conversion trigger bits
    logic [NUM_PORTS-1:0]  abort_q;         // abort pulses
    logic [NUM_PORTS-1:0]  active_q;        // conversion in progress
    logic [NUM_PORTS-1:0]  start_set;       // start written this edge
    logic [NUM_PORTS-1:0]  abort_set;       // abort written this edge
    logic [IRQ_W-1:0]      irq_status_q;    // sticky events
    logic [IRQ_W-1:0]      irq_status_d;    // next sticky events
    logic [IRQ_W-1:0]      irq_enable_q;    // event enables
    logic [IRQ_W-1:0]      irq_enable_d;    // next enables
    logic [IRQ_W-1:0]      irq_events;      // events this cycle
    logic [IRQ_W-1:0]      irq_clear;       // clear written this edge
    logic                  irq_q;           // registered interrupt
    logic [`RB_RESULT_W:0] det_word  [NUM_PORTS];  // detection results
    logic [`RB_RESULT_W:0] volt_word [NUM_PORTS];  // voltage results
    logic [7:0]            state_sel;       // state byte of the port
    logic [7:0]            det_lo_sel;      // detection low byte
    logic [7:0]            det_hi_sel;      // detection high byte
    logic [7:0]            volt_lo_sel;     // voltage low byte
    logic [7:0]            volt_hi_sel;     // voltage high byte
    logic [7:0]            ctrl_sel;        // control byte

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {rst_sync_q, rst_meta_q} <= `RB_SYNC_RST;
        end else begin
            {rst_sync_q, rst_meta_q} <= {rst_meta_q, 1'b1};
        end
    end

    // address fields
    assign is_global = paddr[`RB_GLOBAL_BIT];
    assign port_idx  = paddr[`RB_PORT_MSB:`RB_PORT_LSB];
    assign sel       = paddr[`RB_SEL_MSB:`RB_SEL_LSB];
    assign port_ok   = 32'(port_idx) < NUM_PORTS;

    // take an access phase once, answer on the next cycle
    assign go     = clk_en && psel && penable && (apb_state_q == APB_IDLE);
    // writes land at the edge where ready is seen high
    assign commit = clk_en && psel && penable && pready_q;

    // per-port result slots
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_slot
            port_result_slot u_slot (
                .clk           (ref_clk),
                .rst_sync_n    (rst_sync_q),
                .clk_en        (clk_en),
                .detect_begin  (detect_begin[gi]),
                .detect_done   (detect_done[gi]),
                .voltage_begin (voltage_begin[gi]),
                .voltage_done  (voltage_done[gi]),
                .conv_data     (conv_data[gi*15 +: 15]),
                .det_word_q    (det_word[gi]),
                .volt_word_q   (volt_word[gi])
            );
        end
    endgenerate

    // bytes of the addressed port
    always_comb begin
        state_sel   = 8'h00;
        det_lo_sel  = 8'h00;
        det_hi_sel  = 8'h00;
        volt_lo_sel = 8'h00;
        volt_hi_sel = 8'h00;
        ctrl_sel    = 8'h00;
        if (port_ok) begin
            state_sel[2:0] = port_state_in[port_idx];
            state_sel[`RB_STATE_ACTIVE] = active_q[port_idx];
            det_lo_sel  = det_word[port_idx][7:0];
            det_hi_sel  = det_word[port_idx][15:8];
            volt_lo_sel = volt_word[port_idx][7:0];
            volt_hi_sel = volt_word[port_idx][15:8];
            ctrl_sel[`RB_CTRL_START] = start_q[port_idx];
        end
    end

    // read mux, unused upper bits read zero
    always_comb begin
        rd_data_d = `RB_WORD_RST;
        rd_err_d  = 1'b0;
        if (is_global) begin
            case (sel)
                `RB_SEL_IRQ_STAT: rd_data_d[IRQ_W-1:0] = irq_status_q;
                `RB_SEL_IRQ_EN:   rd_data_d[IRQ_W-1:0] = irq_enable_q;
                `RB_SEL_IRQ_CLR:  rd_data_d = `RB_WORD_RST;  // write-only
                default:          rd_err_d = 1'b1;
            endcase
        end else if (!port_ok) begin
            rd_err_d = 1'b1;
        end else begin
            case (sel)
                `RB_SEL_CONTROL: rd_data_d[7:0] = ctrl_sel;
                `RB_SEL_STATE:   rd_data_d[7:0] = state_sel;
                `RB_SEL_DET_LO:  rd_data_d[7:0] = det_lo_sel;
                `RB_SEL_DET_HI:  rd_data_d[7:0] = det_hi_sel;
                `RB_SEL_VOLT_LO: rd_data_d[7:0] = volt_lo_sel;
                `RB_SEL_VOLT_HI: rd_data_d[7:0] = volt_hi_sel;
                default:         rd_err_d = 1'b1;
            endcase
        end
    end

    // bus answer state machine
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            apb_state_q <= APB_IDLE;
        end else if (clk_en) begin
            case (apb_state_q)
                APB_IDLE:   if (go) apb_state_q <= APB_ANSWER;
                APB_ANSWER: apb_state_q <= APB_IDLE;
                default:    apb_state_q <= APB_IDLE;
            endcase
        end
    end

    // ready, error and read data, one cycle wide
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `RB_WORD_RST;
        end else if (clk_en) begin
            pready_q  <= go;
            pslverr_q <= go && rd_err_d;
            // data only for reads, zero otherwise
            prdata_q  <= (go && !pwrite) ? rd_data_d : `RB_WORD_RST;
        end
    end

    // decoded writes for each port
    always_comb begin
        start_set = '0;
        abort_set = '0;
        if (commit && pwrite && !is_global && port_ok &&
            sel == `RB_SEL_CONTROL) begin
            start_set[port_idx] = pwdata[`RB_CTRL_START];
            abort_set[port_idx] = pwdata[`RB_CTRL_ABORT];
        end
    end

    // trigger bit: set by software, dropped when conversion begins
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            start_q <= '0;
        end else if (clk_en) begin
            start_q <= start_set |
                       (start_q & ~(detect_begin | voltage_begin | abort_set));
        end
    end

    // abort is a one-cycle pulse to the converter
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            abort_q <= '0;
        end else if (clk_en) begin
            abort_q <= abort_set;
        end
    end

    // converter activity per port
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            active_q <= '0;
        end else if (clk_en) begin
            active_q <= detect_begin | voltage_begin |
                        ((active_q | start_set) &
                         ~(detect_done | voltage_done | abort_set));
        end
    end

    // event sources: low half detection, high half voltage
    assign irq_events = {voltage_done, detect_done};

    // clear and enable writes
    always_comb begin
        irq_clear    = '0;
        irq_enable_d = irq_enable_q;
        if (commit && pwrite && is_global) begin
            if (sel == `RB_SEL_IRQ_CLR) begin
                irq_clear = pwdata[IRQ_W-1:0];
            end
            if (sel == `RB_SEL_IRQ_EN) begin
                irq_enable_d = pwdata[IRQ_W-1:0];
            end
        end
        // a new event wins over a clear in the same cycle
        irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
    end

    // sticky status and enables
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            irq_status_q <= '0;
            irq_enable_q <= '0;
        end else if (clk_en) begin
            irq_status_q <= irq_status_d;
            irq_enable_q <= irq_enable_d;
        end
    end

    // interrupt level follows the next status, so no extra lag
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(irq_status_d & irq_enable_d);
        end
    end

    // outputs straight from flops
    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign adc_start = start_q;
    assign adc_abort = abort_q;
    assign irq       = irq_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_q);

    logic rd_go;                             // read access taken
    assign rd_go = go && !pwrite && !is_global && port_ok;

    a_state_code: assert property (
        rd_go && sel == `RB_SEL_STATE
        |=> prdata_q[2:0] == $past(state_sel[2:0]) && prdata_q[31:5] == 27'h0)
        else $error("state code readback wrong");
    a_det_low_read: assert property (
        rd_go && sel == `RB_SEL_DET_LO
        |=> prdata_q == {24'h0, $past(det_lo_sel)} && pready_q)
        else $error("detection low byte wrong");
    a_det_high_read: assert property (
        rd_go && sel == `RB_SEL_DET_HI
        |=> prdata_q == {24'h0, $past(det_hi_sel)} && !pslverr_q)
        else $error("detection high byte wrong");
    a_volt_low_read: assert property (
        rd_go && sel == `RB_SEL_VOLT_LO
        |=> prdata_q == {24'h0, $past(volt_lo_sel)} && pready_q)
        else $error("voltage low byte wrong");
    a_volt_high_read: assert property (
        rd_go && sel == `RB_SEL_VOLT_HI
        |=> prdata_q[7:0] == $past(volt_hi_sel) && !pslverr_q)
        else $error("voltage high byte wrong");
    // trigger drops per port
    // any port whose begin arrives with its trigger set and no start write that cycle must lose the trigger
    a_start_clears: assert property (
        clk_en && |(start_q & (detect_begin | voltage_begin) & ~start_set)
        |=> (start_q & $past(start_q & (detect_begin | voltage_begin) & ~start_set)) == '0)
        else $error("trigger bit not self-cleared");
    a_active_done: assert property (
        clk_en && (detect_done[0] || voltage_done[0])
        && !detect_begin[0] && !voltage_begin[0] |=> !active_q[0])
        else $error("active bit stuck after done");
    a_active_begin: assert property (
        clk_en && detect_begin[0] |=> active_q[0] [*1] ##1 1'b1)
        else $error("active bit missing at begin");
    a_ready_pulse: assert property (
        clk_en && pready_q |=> !pready_q)
        else $error("ready held beyond one cycle");
    // an enable write in the same cycle is followed through its next value
    a_irq_level: assert property (
        clk_en && (|(irq_status_q & irq_enable_d)) && irq_clear == '0
        |=> irq_q)
        else $error("interrupt not raised");

    c_det_read: cover property (rd_go && sel == `RB_SEL_DET_HI ##1 prdata_q[7]);
    c_volt_done: cover property (clk_en && voltage_done[0] ##[1:20] irq_q);
    // main scenarios: flagged read, interrupt, trigger run, refused address
    c_start_run: cover property (start_q[3] ##[1:20] active_q[3] && !start_q[3]);
    c_unmapped: cover property (pslverr_q);
endmodule : port_adc_result_readback
`default_nettype wire

// ### port_adc_result_readback_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "result_readback_map.svh"
module port_adc_result_readback_tb_top;
    import rb_pkg::*;
    localparam int NP = 4;
    // bus, converter and result signals
    logic                 ref_clk, rst_n, clk_en, psel, penable, pwrite;
    logic [8:0]           paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic                 pready, pslverr, irq, err;
    port_state_t [NP-1:0] port_state_in;
    logic [NP-1:0]        detect_begin, detect_done, voltage_begin, voltage_done;
    logic [NP-1:0]        adc_start, adc_abort;
    logic [NP*15-1:0]     conv_data;
    logic [14:0]          dat;
    logic [14:0]          last_d [2][NP];   // expected result per kind and port
    logic [2*NP-1:0]      exp_stat;         // expected sticky status
    int                   error_cnt, checked, p, k, n;
    integer               seed;

    port_adc_result_readback #(.NUM_PORTS(NP)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_state_in(port_state_in), .detect_begin(detect_begin),
        .detect_done(detect_done), .voltage_begin(voltage_begin), .voltage_done(voltage_done),
        .conv_data(conv_data), .adc_start(adc_start), .adc_abort(adc_abort), .irq(irq)
    );

    // free-running clock
    always #20 ref_clk = ~ref_clk;

    // compares a register word
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    // compares a single output pin
    task automatic chk_pin(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_pin

    // one bus transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [8:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // wait for ready at a rising edge, the watchdog bounds a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // byte address of a port register and of a global register
    function automatic logic [8:0] ra(input int pp, input logic [3:0] s);
        return {1'b0, 2'(pp), s, 2'b00};
    endfunction : ra
    function automatic logic [8:0] ga(input logic [3:0] s);
        return {3'b100, s, 2'b00};
    endfunction : ga

    // converter event pulses, m = {voltage_done, voltage_begin, detect_done, detect_begin}
    task automatic evt(input int pp, input logic [3:0] m, input logic [14:0] d);
        @(posedge ref_clk);
        detect_begin[pp]  <= m[0];
        detect_done[pp]   <= m[1];
        voltage_begin[pp] <= m[2];
        voltage_done[pp]  <= m[3];
        conv_data[pp*15 +: 15] <= d;
        if (m[1]) last_d[0][pp] = d;
        if (m[3]) last_d[1][pp] = d;
        if (m[1]) exp_stat[pp] = 1'b1;
        if (m[3]) exp_stat[NP+pp] = 1'b1;
        @(posedge ref_clk);
        {detect_begin, detect_done, voltage_begin, voltage_done} <= '0;
        conv_data <= ~conv_data;
    endtask : evt

    // reads both bytes of a result, kind 0 detection, 1 voltage
    task automatic chk_result(input int pp, input int kk, input logic f);
        logic [3:0] s;
        s = kk ? `RB_SEL_VOLT_LO : `RB_SEL_DET_LO;
        apb(1'b0, ra(pp, s), 32'h0);
        chk_word(rd, {24'h0, last_d[kk][pp][7:0]}, "result low");
        apb(1'b0, ra(pp, s + 4'h1), 32'h0);
        chk_word(rd, {24'h0, f, last_d[kk][pp][14:8]}, "result high");
    endtask : chk_result

    // reads the state register
    task automatic chk_state(input int pp, input logic act);
        apb(1'b0, ra(pp, `RB_SEL_STATE), 32'h0);
        chk_word(rd, {28'h0, act, 3'(port_state_in[pp])}, "state");
    endtask : chk_state

    // ends the run with the verdict
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end

    // main sequence
    initial begin
        seed = 10701;
        ref_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {detect_begin, detect_done, voltage_begin, voltage_done} = '0;
        port_state_in = {NP{ST_DISABLED}};
        conv_data = '0;
        exp_stat = '0;
        error_cnt = 0;
        checked = 0;
        for (int i = 0; i < NP; i++) begin
            last_d[0][i] = 15'h0000;
            last_d[1][i] = 15'h0000;
        end
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_pin(irq, 1'b0, "irq after reset");
        // reset values of all results
        for (int i = 0; i < NP; i++) begin
            chk_result(i, 0, 1'b0);
            chk_result(i, 1, 1'b0);
        end
        // every state code
        for (int c = 0; c < 8; c++) begin
            port_state_in[c % NP] <= port_state_t'(3'(c));
            chk_state(c % NP, 1'b0);
        end
        // random measurements: begin clears flag, done sets it with data
        for (int i = 0; i < 16; i++) begin
            p = $unsigned($random(seed)) % NP;
            k = (i < 8) ? i % 2 : $unsigned($random(seed)) % 2;
            dat = 15'($random(seed));
            evt(p, k ? 4'b0100 : 4'b0001, dat);
            chk_result(p, k, 1'b0);
            chk_state(p, 1'b1);
            evt(p, k ? 4'b1000 : 4'b0010, dat);
            chk_result(p, k, 1'b1);
            chk_state(p, 1'b0);
        end
        // begin and done together: done wins for the flag
        evt(2, 4'b0011, 15'h7FFF);
        chk_result(2, 0, 1'b1);
        evt(2, 4'b0010, 15'h4000);
        // frozen clock enable drops a done pulse, result and flag keep their values
        dat = last_d[1][0];
        k = exp_stat[NP];
        clk_en <= 1'b0;
        evt(0, 4'b1000, 15'h1234);
        clk_en <= 1'b1;
        last_d[1][0] = dat;
        exp_stat[NP] = k[0];
        chk_result(0, 1, k[0]);
        // start bit, abort pulse, self clearing on begin
        apb(1'b1, ra(3, `RB_SEL_CONTROL), 32'h0000_0008);
        @(negedge ref_clk);
        chk_pin(adc_start[3], 1'b1, "start set");
        chk_state(3, 1'b1);
        apb(1'b1, ra(3, `RB_SEL_CONTROL), 32'h0000_0004);
        n = 0;
        repeat (3) begin
            @(negedge ref_clk);
            if (adc_abort[3] === 1'b1) n++;
        end
        chk_word(32'(n), 32'h1, "abort pulse width");
        chk_pin(adc_start[3], 1'b0, "start after abort");
        chk_state(3, 1'b0);
        apb(1'b1, ra(3, `RB_SEL_CONTROL), 32'h0000_0008);
        evt(3, 4'b0100, 15'h0);
        @(negedge ref_clk);
        chk_pin(adc_start[3], 1'b0, "start self clear");
        apb(1'b0, ra(3, `RB_SEL_CONTROL), 32'h0);
        chk_word(rd, 32'h0, "control readback");
        evt(3, 4'b1000, 15'h5A5A);
        chk_result(3, 1, 1'b1);
        // read-only result and unmapped address
        apb(1'b1, ra(1, `RB_SEL_DET_LO), 32'h0000_00FF);
        chk_word({31'h0, err}, 32'h0, "read-only write error");
        chk_result(1, 0, exp_stat[1]);
        apb(1'b0, 9'h10C, 32'h0);
        chk_word({31'h0, err}, 32'h1, "unmapped error");
        chk_word(rd, 32'h0, "unmapped data");
        // interrupt: sticky status, mask, clear
        apb(1'b0, ga(`RB_SEL_IRQ_STAT), 32'h0);
        chk_word(rd, 32'(exp_stat), "irq status");
        apb(1'b1, ga(`RB_SEL_IRQ_CLR), 32'h0000_00FF);
        apb(1'b1, ga(`RB_SEL_IRQ_EN), 32'(1 << (NP + 1)));
        evt(1, 4'b0010, 15'h0F0F);
        repeat (2) @(negedge ref_clk);
        chk_pin(irq, 1'b0, "irq masked");
        evt(1, 4'b1000, 15'h7001);
        repeat (2) @(negedge ref_clk);
        chk_pin(irq, 1'b1, "irq raised");
        apb(1'b1, ga(`RB_SEL_IRQ_CLR), 32'(1 << (NP + 1)));
        repeat (2) @(negedge ref_clk);
        chk_pin(irq, 1'b0, "irq cleared");
        apb(1'b0, ga(`RB_SEL_IRQ_STAT), 32'h0);
        chk_word(rd, 32'h2, "status after clear");
        tally_and_finish();
    end
endmodule : port_adc_result_readback_tb_top
`default_nettype wire
